// [rtl/isr_slave.sv]
`include "isr_cfg.svh"
`default_nettype none

// Behaviour
// - 10-bit first byte: prefix and masked A9:A8
// - Valid first byte: ack, clear flags, interrupt
// - Second byte masked match sets ten_bit_matched
// - Repeated start: first byte alone suffices
// - General call only when enabled, always write
// - General call: ack, flag, buffer, interrupt
// - General call still seen in 10-bit mode
// - Enforce bit refuses every reserved address except the 11110xx 10-bit upper byte
// - 7-bit mismatch ignores bus until stop
// - 10-bit mismatch ignores bus until stop
// - Reserved patterns never matched through mask
// - 11110xx only as 10-bit upper byte
// - Eighth fall: buffer, full flag, interrupt
// - Ack unless full or overflow before byte
// - Full: skip, overflow; overflow only: no ack
// - Read clears full; overflow cleared explicitly
// - Stretch enabled: ninth fall of a data byte holds clock low
// - Software release frees the clock line
// - One interrupt per accepted address byte, per data byte
// - Mask bit one makes position don't-care
// - Bits sampled on serial clock rising edge
// - Start and stop flags track bus events
module isr_slave (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl_clk,
    // Serial clock line, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    // Serial data line, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Configuration
    input wire isr_pkg::isr_ctl_t ctl,
    // Software strobes, one cycle each
    input wire logic rx_buffer_read,
    input wire logic rx_overflow_clear,
    input wire logic clock_release_set,
    // Status and data
    output isr_pkg::isr_stat_t status,
    output logic [7:0] receive_buffer,
    output logic slave_irq
);

    typedef struct packed {
        logic scl_m;
        logic scl_r;
        logic scl_p;
        logic sda_m;
        logic sda_r;
        logic sda_p;
        logic tog_m;
        logic tog_r;
        logic tog_p;
        isr_pkg::isr_state_t st;
        isr_pkg::isr_state_t nxt;
        logic [`ISR_CNT_W-1:0] cnt;
        logic [7:0] sr;
        logic [7:0] rcv;
        logic irq9;
        logic irq;
        logic sda_oen;
        logic scl_oen;
        isr_pkg::isr_stat_t stat;
    } isr_core_t;

    isr_core_t s_q;
    isr_core_t s_d;
    logic link_bit;
    logic link_tog;

    ////////////////////////////////////////////////////////////////////////////
    // Link side sampler
    isr_link u_link (
        .scl_clk(scl_clk),
        .reset(reset),
        .sda_in(sda_in),
        .link_bit(link_bit),
        .link_tog(link_tog)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus events, from second stage onward only
    logic scl_fall;
    logic bit_ev;
    logic start_ev;
    logic stop_ev;
    logic byte_end;
    logic ack_end;
    logic [6:0] addr7;
    logic reserved7;
    logic exact7;
    logic mask7_ok;
    logic ok7;
    logic ok10a;
    logic ok10b;
    logic gc_hit;

    assign scl_fall = s_q.scl_p & ~s_q.scl_r;
    assign bit_ev = s_q.tog_r ^ s_q.tog_p;
    assign start_ev = s_q.scl_r & s_q.scl_p & s_q.sda_p & ~s_q.sda_r;
    assign stop_ev = s_q.scl_r & s_q.scl_p & ~s_q.sda_p & s_q.sda_r;
    assign byte_end = scl_fall & (s_q.cnt == `ISR_CNT_BYTE);
    assign ack_end = scl_fall & (s_q.cnt == `ISR_CNT_ACK);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign addr7 = s_q.sr[7:1];
    assign reserved7 = (addr7[6:3] == `ISR_RSV_LOW4) || (addr7[6:2] == `ISR_RSV_HIGH5)
        || (addr7[6:2] == `ISR_TEN_PREFIX);
    assign exact7 = (addr7 == ctl.own_address[6:0]);
    assign mask7_ok = (((addr7 ^ ctl.own_address[6:0]) & ~ctl.address_mask[6:0]) == 7'h00);
    // Reserved only by exact match, never under enforce, never as 11110xx
    assign ok7 = mask7_ok && !s_q.sr[0]
        && !(reserved7 && (!exact7 || ctl.reserved_enforce))
        && (addr7[6:2] != `ISR_TEN_PREFIX) && (s_q.sr != `ISR_GC_BYTE);
    assign ok10a = (s_q.sr[7:3] == `ISR_TEN_PREFIX) && !s_q.sr[0]
        && (((s_q.sr[2:1] ^ ctl.own_address[9:8]) & ~ctl.address_mask[9:8]) == 2'h0);
    assign ok10b = (((s_q.sr ^ ctl.own_address[7:0]) & ~ctl.address_mask[7:0]) == 8'h00);
    // General call sits in the reserved set, so enforce refuses it as well
    assign gc_hit = (s_q.sr == `ISR_GC_BYTE) && ctl.general_call_enable
        && !ctl.reserved_enforce;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.scl_m = scl_in;
        s_d.scl_r = s_q.scl_m;
        s_d.scl_p = s_q.scl_r;
        s_d.sda_m = sda_in;
        s_d.sda_r = s_q.sda_m;
        s_d.sda_p = s_q.sda_r;
        s_d.tog_m = link_tog;
        s_d.tog_r = s_q.tog_m;
        s_d.tog_p = s_q.tog_r;
        // Clears first so that a same-cycle hardware set wins
        if (rx_buffer_read) begin
            s_d.stat.rx_buffer_full = 1'b0;
        end
        if (rx_overflow_clear) begin
            s_d.stat.rx_overflow = 1'b0;
        end
        if (clock_release_set) begin
            s_d.stat.clock_release = 1'b1;
        end
        if (!ctl.module_enable) begin
            s_d.st = isr_pkg::ISR_IDLE;
            s_d.cnt = `ISR_CNT_ZERO;
            s_d.sda_oen = `ISR_RST_OEN;
            s_d.stat.start_seen = 1'b0;
            s_d.stat.stop_seen = 1'b0;
            s_d.stat.ten_bit_matched = 1'b0;
            s_d.stat.general_call_seen = 1'b0;
            s_d.stat.clock_release = `ISR_RST_RELEASE;
        end else if (stop_ev) begin
            s_d.st = isr_pkg::ISR_IDLE;
            s_d.cnt = `ISR_CNT_ZERO;
            s_d.sda_oen = `ISR_RST_OEN;
            s_d.stat.stop_seen = 1'b1;
            s_d.stat.start_seen = 1'b0;
            s_d.stat.ten_bit_matched = 1'b0;
            s_d.stat.general_call_seen = 1'b0;
        end else if (start_ev) begin
            s_d.stat.start_seen = 1'b1;
            s_d.stat.stop_seen = 1'b0;
            s_d.sda_oen = `ISR_RST_OEN;
            s_d.cnt = `ISR_CNT_ZERO;
            // An ignored message stays ignored across repeated starts
            if (s_q.st != isr_pkg::ISR_IGNORE) begin
                s_d.st = isr_pkg::ISR_ADDR1;
            end
        end else if (s_q.st != isr_pkg::ISR_IDLE && s_q.st != isr_pkg::ISR_IGNORE) begin
            if (bit_ev) begin
                if (s_q.cnt < `ISR_CNT_BYTE) begin
                    s_d.sr = {s_q.sr[6:0], link_bit};
                end
                s_d.cnt = s_q.cnt + 4'h1;
            end
            if (byte_end) begin
                s_d.irq9 = 1'b0;
                s_d.nxt = isr_pkg::ISR_DATA;
                unique case (s_q.st)
                    isr_pkg::ISR_ADDR1: begin
                        if (gc_hit) begin
                            s_d.sda_oen = 1'b0;
                            s_d.stat.general_call_seen = 1'b1;
                            s_d.stat.data_not_address = 1'b0;
                            s_d.stat.read_write = 1'b0;
                            s_d.rcv = s_q.sr;
                            s_d.stat.rx_buffer_full = 1'b1;
                            s_d.irq9 = 1'b1;
                        end else if (ctl.ten_bit_mode && ok10a) begin
                            s_d.sda_oen = 1'b0;
                            s_d.stat.data_not_address = 1'b0;
                            s_d.stat.read_write = 1'b0;
                            s_d.irq9 = 1'b1;
                            // After a repeated start the lower byte is not sent again
                            if (!s_q.stat.ten_bit_matched) begin
                                s_d.nxt = isr_pkg::ISR_ADDR2;
                            end
                        end else if (!ctl.ten_bit_mode && ok7) begin
                            s_d.sda_oen = 1'b0;
                            s_d.stat.data_not_address = 1'b0;
                            s_d.stat.read_write = 1'b0;
                            s_d.irq9 = 1'b1;
                        end else begin
                            s_d.st = isr_pkg::ISR_IGNORE;
                        end
                    end
                    isr_pkg::ISR_ADDR2: begin
                        if (ok10b) begin
                            s_d.sda_oen = 1'b0;
                            s_d.stat.ten_bit_matched = 1'b1;
                            s_d.irq9 = 1'b1;
                        end else begin
                            s_d.st = isr_pkg::ISR_IGNORE;
                        end
                    end
                    isr_pkg::ISR_DATA: begin
                        s_d.stat.data_not_address = 1'b1;
                        s_d.irq = 1'b1;
                        if (s_q.stat.rx_buffer_full) begin
                            s_d.stat.rx_overflow = 1'b1;
                            s_d.stat.rx_buffer_full = 1'b1;
                        end else begin
                            s_d.rcv = s_q.sr;
                            s_d.stat.rx_buffer_full = 1'b1;
                            s_d.sda_oen = s_q.stat.rx_overflow;
                        end
                    end
                    default: begin
                        s_d.st = isr_pkg::ISR_IGNORE;
                    end
                endcase
            end
            if (ack_end) begin
                s_d.sda_oen = `ISR_RST_OEN;
                s_d.cnt = `ISR_CNT_ZERO;
                s_d.st = s_q.nxt;
                s_d.irq = s_q.irq9;
                s_d.irq9 = 1'b0;
                if (s_q.st == isr_pkg::ISR_DATA && ctl.rx_stretch_enable) begin
                    s_d.stat.clock_release = 1'b0;
                end
            end
        end
        s_d.scl_oen = s_d.stat.clock_release;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= isr_pkg::ISR_IDLE;
            s_q.nxt <= isr_pkg::ISR_IDLE;
            s_q.sda_oen <= `ISR_RST_OEN;
            s_q.scl_oen <= `ISR_RST_OEN;
            s_q.stat.clock_release <= `ISR_RST_RELEASE;
            s_q.rcv <= `ISR_RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // Line levels are only ever pulled low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = s_q.scl_oen;
    assign sda_oe_n = s_q.sda_oen;
    assign status = s_q.stat;
    assign receive_buffer = s_q.rcv;
    assign slave_irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic ev_ok;
    assign ev_ok = ctl.module_enable && !start_ev && !stop_ev;

    property p_gc_ack;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && byte_end && s_q.st == isr_pkg::ISR_ADDR1 && gc_hit)
            |=> (!sda_oe_n && status.general_call_seen && status.rx_buffer_full);
    endproperty
    a_gc_ack: assert property (p_gc_ack) else $error("general call not taken");

    property p_gc_off;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && byte_end && s_q.st == isr_pkg::ISR_ADDR1 && s_q.sr == 8'h00
            && !ctl.general_call_enable) |=> sda_oe_n;
    endproperty
    a_gc_off: assert property (p_gc_off) else $error("general call acked while off");

    property p_reserved;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && byte_end && s_q.st == isr_pkg::ISR_ADDR1 && !ctl.ten_bit_mode
            && ctl.reserved_enforce && s_q.sr[7:4] == 4'h0) |=> sda_oe_n;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address acked");

    property p_prefix7;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && byte_end && s_q.st == isr_pkg::ISR_ADDR1 && !ctl.ten_bit_mode
            && s_q.sr[7:3] == 5'h1E) |=> (sda_oe_n && s_q.st == isr_pkg::ISR_IGNORE);
    endproperty
    a_prefix7: assert property (p_prefix7) else $error("10-bit prefix taken as 7-bit");

    property p_overrun;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && byte_end && s_q.st == isr_pkg::ISR_DATA && status.rx_buffer_full)
            |=> (status.rx_overflow && sda_oe_n && slave_irq && $stable(receive_buffer));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun mishandled");

    property p_read_clear;
        @(posedge sys_clk) disable iff (reset)
        (rx_buffer_read && !(byte_end && s_q.st == isr_pkg::ISR_DATA)
            && !(byte_end && s_q.st == isr_pkg::ISR_ADDR1 && gc_hit))
            |=> !status.rx_buffer_full;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("full flag kept on read");

    property p_ov_hold;
        @(posedge sys_clk) disable iff (reset)
        (status.rx_overflow && !rx_overflow_clear) |=> status.rx_overflow;
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overflow lost");

    property p_stretch;
        @(posedge sys_clk) disable iff (reset)
        (ev_ok && ack_end && s_q.st == isr_pkg::ISR_DATA && ctl.rx_stretch_enable)
            |=> !status.clock_release && !scl_oe_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch");

    property p_release;
        @(posedge sys_clk) disable iff (reset)
        (clock_release_set && !ack_end) |=> status.clock_release && scl_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("clock not released");

    property p_start;
        @(posedge sys_clk) disable iff (reset)
        (ctl.module_enable && start_ev && !stop_ev) |=> (status.start_seen && !status.stop_seen);
    endproperty
    a_start: assert property (p_start) else $error("start flags wrong");

    property p_ignore;
        @(posedge sys_clk) disable iff (reset)
        (s_q.st == isr_pkg::ISR_IGNORE && ctl.module_enable && !stop_ev)
            |=> (s_q.st == isr_pkg::ISR_IGNORE && sda_oe_n && !slave_irq);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored message answered");

endmodule // isr_slave

`default_nettype wire

// [rtl/isr_cfg.svh]
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// Bit counts within one byte frame
`define ISR_CNT_W 4
`define ISR_CNT_BYTE 4'h8
`define ISR_CNT_ACK 4'h9
`define ISR_CNT_ZERO 4'h0

// Fixed prefix of a 10-bit upper address byte
`define ISR_TEN_PREFIX 5'h1E
// Reserved 7-bit groups, upper address bits
`define ISR_RSV_LOW4 4'h0
`define ISR_RSV_HIGH5 5'h1F
`define ISR_GC_BYTE 8'h00

// Reset values
`define ISR_RST_RELEASE 1'b1
`define ISR_RST_OEN 1'b1
`define ISR_RST_BYTE 8'h00

`endif

// [rtl/isr_pkg.sv]
`default_nettype none

package isr_pkg;

    typedef enum logic [2:0] {
        ISR_IDLE,
        ISR_ADDR1,
        ISR_ADDR2,
        ISR_DATA,
        ISR_IGNORE
    } isr_state_t;

    typedef struct packed {
        logic module_enable;
        logic ten_bit_mode;
        logic general_call_enable;
        logic reserved_enforce;
        logic rx_stretch_enable;
        logic [9:0] own_address;
        logic [9:0] address_mask;
    } isr_ctl_t;

    typedef struct packed {
        logic rx_buffer_full;
        logic rx_overflow;
        logic data_not_address;
        logic read_write;
        logic ten_bit_matched;
        logic general_call_seen;
        logic start_seen;
        logic stop_seen;
        logic clock_release;
    } isr_stat_t;

    typedef struct packed {
        logic bit_v;
        logic tog;
    } isr_link_st_t;

endpackage : isr_pkg

`default_nettype wire

// [rtl/isr_link.sv]
`default_nettype none

module isr_link (
    // Link clock and reset
    input wire logic scl_clk,
    input wire logic reset,
    // Data pin
    input wire logic sda_in,
    // Sampled bit towards system domain
    output logic link_bit,
    output logic link_tog
);

    isr_pkg::isr_link_st_t s_q;
    isr_pkg::isr_link_st_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Bit held stable until the next rising edge, long after the toggle lands
    always_comb begin
        s_d = s_q;
        s_d.bit_v = sda_in;
        s_d.tog = ~s_q.tog;
    end

    always_ff @(posedge scl_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link_bit = s_q.bit_v;
    assign link_tog = s_q.tog;

endmodule // isr_link

`default_nettype wire

// [verif/isr_mstr_model.sv]
`default_nettype none

// Bus master model; a 1 on a pull output drags that open-drain line low
module isr_mstr_model #(
    parameter int HALF_NS = 64
) (
    // Resolved line levels
    input wire logic scl_bus,
    input wire logic sda_bus,
    // Pull-down requests
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    int hang_n;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hang_n = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slow phases: the slave synchroniser needs several system cycles per phase
    task automatic up();
        int i;
        i = 0;
        scl_low = 1'b0;
        // Slave may stretch, so the wait is bounded
        while (scl_bus !== 1'b1 && i < 5000) begin
            #1;
            i++;
        end
        if (i >= 5000) hang_n++;
    endtask

    task automatic down();
        #(HALF_NS);
        scl_low = 1'b1;
        #(HALF_NS / 2);
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        #(HALF_NS / 2);
        up();
        #(HALF_NS / 2);
        sda_low = 1'b1;
        down();
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        #(HALF_NS / 2);
        up();
        #(HALF_NS / 2);
        sda_low = 1'b0;
        #(HALF_NS);
    endtask

    // Eight bits MSB first, then the acknowledge slot with the data line released
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            #(HALF_NS / 2);
            up();
            down();
        end
        sda_low = 1'b0;
        #(HALF_NS / 2);
        up();
        ack = ~sda_bus;
        down();
    endtask
endmodule // isr_mstr_model

`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    isr_pkg::isr_ctl_t ctl;
    logic rx_buffer_read, rx_overflow_clear, clock_release_set;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, slave_irq, m_scl_low, m_sda_low;
    isr_pkg::isr_stat_t status;
    logic [7:0] receive_buffer;
    wire scl_w;
    wire sda_w;
    int n_errors = 0;
    int check_count = 0;
    int irq_n = 0;

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (slave_irq === 1'b1) irq_n++;

    // Pull-ups win unless some party pulls low
    assign scl_w = ~(m_scl_low | (~scl_oe_n & ~scl_out));
    assign sda_w = ~(m_sda_low | (~sda_oe_n & ~sda_out));

    isr_slave dut_u (.sys_clk(sys_clk), .reset(reset), .scl_clk(scl_w), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .ctl(ctl), .rx_buffer_read(rx_buffer_read),
        .rx_overflow_clear(rx_overflow_clear), .clock_release_set(clock_release_set),
        .status(status), .receive_buffer(receive_buffer), .slave_irq(slave_irq));

    isr_mstr_model #(.HALF_NS(64)) mst_u (.scl_bus(scl_w), .sda_bus(sda_w),
        .scl_low(m_scl_low), .sda_low(m_sda_low));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic strobe(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        cyc(2);
    endtask

    task automatic cfg(input logic [9:0] own, input logic [9:0] msk, input logic ten,
                       input logic gce, input logic enf, input logic str);
        @(negedge sys_clk);
        ctl = {1'b1, ten, gce, enf, str, own, msk};
    endtask

    task automatic byte_ack(input logic [7:0] b, input logic e);
        logic a;
        mst_u.send_byte(b, a);
        // A stuck clock line ends the run at once
        if (mst_u.hang_n != 0) begin
            n_errors++;
            print_verdict();
        end
        chk_bit("ack", e, a);
        cyc(8);
    endtask

    // Expected acknowledge of a 7-bit address byte
    function automatic logic exp_ack7(input logic [7:0] b);
        logic [6:0] a;
        a = b[7:1];
        if (b == 8'h00) return ctl.general_call_enable && !ctl.reserved_enforce;
        if (b[0] || a[6:2] == 5'h1E) return 1'b0;
        if (a[6:3] == 4'h0 || a[6:2] == 5'h1F)
            return !ctl.reserved_enforce && a == ctl.own_address[6:0];
        return ((a ^ ctl.own_address[6:0]) & ~ctl.address_mask[6:0]) == 7'h00;
    endfunction

    // Address, repeated start with own address, stop; one interrupt per accepted address
    task automatic addr_case(input logic [7:0] b);
        logic e1, e2;
        int i0;
        e1 = exp_ack7(b);
        e2 = e1 ? exp_ack7({ctl.own_address[6:0], 1'b0}) : 1'b0;
        i0 = irq_n;
        mst_u.start_cond();
        byte_ack(b, e1);
        mst_u.start_cond();
        byte_ack({ctl.own_address[6:0], 1'b0}, e2);
        mst_u.stop_cond();
        cyc(8);
        chk_byte("irq_count", 8'(32'(e1) + 32'(e2)), 8'(irq_n - i0));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        logic [6:0] own7;
        logic [9:0] o10;
        logic [7:0] d [5];
        int i0;
        ctl = '0;
        rx_buffer_read = 1'b0;
        rx_overflow_clear = 1'b0;
        clock_release_set = 1'b0;
        void'($urandom(98940));
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        chk_bit("start_seen", 1'b0, status.start_seen);
        chk_bit("stop_seen", 1'b0, status.stop_seen);
        chk_bit("clock_release", 1'b1, status.clock_release);
        chk_bit("scl_oe_n", 1'b1, scl_oe_n);
        // Receive path: fill, overrun, partial and full recovery
        own7 = 7'h10 + 7'($urandom % 32'h60);
        foreach (d[i]) d[i] = 8'($urandom);
        cfg({3'h0, own7}, 10'h000, 1'b0, 1'b0, 1'b0, 1'b0);
        cyc(4);
        i0 = irq_n;
        mst_u.start_cond();
        cyc(8);
        chk_bit("start_seen", 1'b1, status.start_seen);
        chk_bit("stop_seen", 1'b0, status.stop_seen);
        byte_ack({own7, 1'b0}, 1'b1);
        chk_bit("data_not_address", 1'b0, status.data_not_address);
        chk_bit("read_write", 1'b0, status.read_write);
        byte_ack(d[0], 1'b1);
        chk_bit("rx_buffer_full", 1'b1, status.rx_buffer_full);
        chk_byte("receive_buffer", d[0], receive_buffer);
        chk_bit("data_not_address", 1'b1, status.data_not_address);
        byte_ack(d[1], 1'b0);
        chk_bit("rx_overflow", 1'b1, status.rx_overflow);
        chk_byte("receive_buffer", d[0], receive_buffer);
        strobe(rx_buffer_read);
        chk_bit("rx_buffer_full", 1'b0, status.rx_buffer_full);
        chk_bit("rx_overflow", 1'b1, status.rx_overflow);
        byte_ack(d[2], 1'b0);
        chk_byte("receive_buffer", d[2], receive_buffer);
        chk_bit("rx_buffer_full", 1'b1, status.rx_buffer_full);
        strobe(rx_overflow_clear);
        strobe(rx_buffer_read);
        chk_bit("rx_overflow", 1'b0, status.rx_overflow);
        byte_ack(d[3], 1'b1);
        mst_u.stop_cond();
        cyc(8);
        chk_bit("stop_seen", 1'b1, status.stop_seen);
        chk_bit("start_seen", 1'b0, status.start_seen);
        chk_byte("irq_count", 8'h05, 8'(irq_n - i0));
        // Stretch after a data byte, then software release
        strobe(rx_buffer_read);
        cfg({3'h0, own7}, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1);
        mst_u.start_cond();
        byte_ack({own7, 1'b0}, 1'b1);
        byte_ack(d[4], 1'b1);
        chk_bit("clock_release", 1'b0, status.clock_release);
        chk_bit("scl_oe_n", 1'b0, scl_oe_n);
        fork
            mst_u.stop_cond();
            begin
                cyc(30);
                chk_bit("scl_line", 1'b0, scl_w);
                strobe(clock_release_set);
            end
        join
        chk_bit("clock_release", 1'b1, status.clock_release);
        chk_bit("scl_oe_n", 1'b1, scl_oe_n);
        // General call accepted in 10-bit mode, then refused in 7-bit mode when disabled
        strobe(rx_buffer_read);
        cfg({3'h0, own7}, 10'h000, 1'b1, 1'b1, 1'b0, 1'b0);
        mst_u.start_cond();
        byte_ack(8'h00, 1'b1);
        chk_bit("general_call_seen", 1'b1, status.general_call_seen);
        chk_bit("rx_buffer_full", 1'b1, status.rx_buffer_full);
        chk_byte("receive_buffer", 8'h00, receive_buffer);
        mst_u.stop_cond();
        strobe(rx_buffer_read);
        cfg({3'h0, own7}, 10'h000, 1'b0, 1'b0, 1'b0, 1'b0);
        addr_case(8'h00);
        // 10-bit match, repeated start, mismatches
        o10 = 10'($urandom);
        cfg(o10, 10'h000, 1'b1, 1'b0, 1'b0, 1'b0);
        mst_u.start_cond();
        byte_ack({5'h1E, o10[9:8], 1'b0}, 1'b1);
        chk_bit("data_not_address", 1'b0, status.data_not_address);
        byte_ack(o10[7:0], 1'b1);
        chk_bit("ten_bit_matched", 1'b1, status.ten_bit_matched);
        mst_u.start_cond();
        byte_ack({5'h1E, o10[9:8], 1'b0}, 1'b1);
        byte_ack(d[1], 1'b1);
        mst_u.stop_cond();
        strobe(rx_buffer_read);
        for (int i = 0; i < 2; i++) begin
            cfg(o10, {i[0], i[0], 8'h00}, 1'b1, 1'b0, 1'b0, 1'b0);
            mst_u.start_cond();
            byte_ack({5'h1E, ~o10[9:8], 1'b0}, i[0]);
            mst_u.stop_cond();
        end
        cfg(o10, 10'h000, 1'b1, 1'b0, 1'b0, 1'b0);
        mst_u.start_cond();
        byte_ack({5'h1E, o10[9:8], 1'b0}, 1'b1);
        byte_ack(o10[7:0] ^ 8'h01, 1'b0);
        mst_u.start_cond();
        byte_ack({5'h1E, o10[9:8], 1'b0}, 1'b0);
        mst_u.stop_cond();
        // Reserved set and mask corners
        cfg(10'h004, 10'h000, 1'b0, 1'b0, 1'b0, 1'b0);
        addr_case(8'h08);
        cfg(10'h004, 10'h000, 1'b0, 1'b0, 1'b1, 1'b0);
        addr_case(8'h08);
        cfg(10'h010, 10'h07F, 1'b0, 1'b0, 1'b0, 1'b0);
        addr_case(8'h0A);
        addr_case(8'h01);
        addr_case(8'hF8);
        addr_case(8'hF0);
        cfg(10'h010, 10'h060, 1'b0, 1'b0, 1'b0, 1'b0);
        addr_case(8'h60);
        // Random addresses, sparse masks, enforce on and off
        for (int k = 0; k < 12; k++) begin
            cfg(10'($urandom), 10'($urandom & $urandom & $urandom), 1'b0, 1'b0,
                1'($urandom), 1'b0);
            if (k % 2 == 0) addr_case({ctl.own_address[6:0] ^ (ctl.address_mask[6:0]
                & 7'($urandom)), 1'b0});
            else addr_case(8'($urandom));
        end
        // A clock line held low past the bound in a start or stop
        if (mst_u.hang_n != 0) n_errors++;
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
